// [logic/repl_pkg.sv]
// Purpose: shared constants and types of the multicast replication engine
// Assumes: 4x mode, one 32-bit datum per fabric clock
// Notes: byte capacities are converted to datums here
package repl_pkg;
  localparam int PORTS         = 16;
  localparam int PORT_W        = 4;
  localparam int GROUPS        = 8;
  localparam int GRP_W         = 3;
  localparam int DATUM_W       = 32;
  localparam int DATUM_BYTES   = 4;
  localparam int ALIGN_BYTES   = 8;
  localparam int HDR_BYTES     = 8;
  localparam int HDR_DATUMS    = HDR_BYTES / DATUM_BYTES;
  localparam int WQ_BYTES      = 2208;
  localparam int WQ_STOP_BYTES = 1936;
  localparam int WQ_WORDS      = WQ_BYTES / DATUM_BYTES;
  localparam int WQ_STOP_WORDS = WQ_STOP_BYTES / DATUM_BYTES;
  localparam int WQ_PTR_W      = $clog2(WQ_WORDS);
  localparam int DESC_DEPTH    = 512;
  localparam int BB_BYTES      = 280;
  localparam int BB_WORDS      = BB_BYTES / DATUM_BYTES;
  localparam int BB_MAX_PKTS   = 8;
  localparam int BB_MIN_FREE   = ALIGN_BYTES / DATUM_BYTES;
  // header layout: datum 0 carries source port, ttl and size bit
  localparam int SRC_PORT_LSB  = 27;
  localparam int TTL_LSB       = 24;
  localparam int TTL_W         = 3;
  localparam logic [2:0] TTL_MAX = 3'h7;
  localparam int TT_BIT        = 20;
  // datum 1 carries the destination identifier
  localparam int DEST16_LSB    = 16;
  localparam int DEST8_LSB     = 24;
  // stored entry: {sop, eop, stomp, data}
  localparam int ENTRY_W       = DATUM_W + 3;
  localparam int E_STOMP       = DATUM_W;
  localparam int E_EOP         = DATUM_W + 1;
  localparam int E_SOP         = DATUM_W + 2;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_SEND = 2'b01,
    RD_DROP = 2'b10
  } rd_state_type;
endpackage : repl_pkg

// [logic/bcast_if.sv]
// Purpose: work queue to broadcast buffer datum path
// Assumes: source only drives valid while ready is high
// Notes: ready already covers the datum offered in the same cycle
`timescale 1ns/1ps
interface bcast_if;
  import repl_pkg::*;
  logic               valid;
  logic               sop;
  logic               eop;
  logic               stomp;
  logic [DATUM_W-1:0] data;
  logic               ready;
  modport src (output valid, sop, eop, stomp, data, input ready);
  modport snk (input valid, sop, eop, stomp, data, output ready);
endinterface : bcast_if

// [logic/group_match.sv]
// Purpose: multicast group lookup from the first two header datums
// Assumes: lowest matching entry wins
// Notes: purely combinational
`timescale 1ns/1ps
module group_match
  import repl_pkg::*;
(
  input  wire logic [DATUM_W-1:0]            word0,
  input  wire logic [DATUM_W-1:0]            word1,
  input  wire logic [GROUPS-1:0]             grp_valid,
  input  wire logic [GROUPS-1:0]             grp_large,
  input  wire logic [GROUPS-1:0][15:0]       grp_dest,
  input  wire logic [GROUPS-1:0][PORTS-1:0]  grp_mask,
  output logic                               hit,
  output logic [GRP_W-1:0]                   grp_idx,
  output logic [PORTS-1:0]                   mask
);
  always_comb begin
    hit = 1'b0;
    grp_idx = '0;
    mask = '0;
    for (int i = GROUPS - 1; i >= 0; i--) begin
      if (grp_valid[i] && (grp_large[i]
          ? (!word0[TT_BIT] && grp_dest[i] == word1[DEST16_LSB +: 16])
          : (word0[TT_BIT] && grp_dest[i][7:0] == word1[DEST8_LSB +: 8]))) begin
        hit = 1'b1;
        grp_idx = GRP_W'(i);
        mask = grp_mask[i];
      end
    end
  end
endmodule : group_match

// [logic/bcast_buffer.sv]
// Purpose: per-egress broadcast buffer, store-and-forward
// Assumes: source honours ready; egress takes one datum per clock
// Notes: storage rounded to 8-byte units, content sent unchanged but ttl
`timescale 1ns/1ps
module bcast_buffer
  import repl_pkg::*;
#(
  parameter int DEPTH    = BB_WORDS,
  parameter int MAX_PKTS = BB_MAX_PKTS
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  bcast_if.snk               bb,
  input  wire logic          eg_gnt,
  output logic               eg_req,
  output logic               eg_valid,
  output logic               eg_sop,
  output logic               eg_eop,
  output logic               eg_stomp,
  output logic [DATUM_W-1:0] eg_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [AW-1:0]      wr_ptr_reg;
  logic [AW-1:0]      rd_ptr_reg;
  logic [CW-1:0]      used_reg;
  logic [3:0]         pkt_cnt_reg;
  logic [3:0]         done_cnt_reg;
  logic               in_pkt_reg;
  logic               wr_odd_reg;
  logic               rd_odd_reg;
  logic               sending_reg;
  logic               eg_req_reg;
  logic               eg_valid_reg;
  logic               eg_sop_reg;
  logic               eg_eop_reg;
  logic               eg_stomp_reg;
  logic [DATUM_W-1:0] eg_data_reg;
  logic [ENTRY_W-1:0] rd_word;
  logic               wr_pad;
  logic               rd_pad;
  logic               rd_end;
  logic               start;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p, input logic two);
    logic [AW:0] s;
    s = {1'b0, p} + {{(AW-1){1'b0}}, two, ~two};
    if (s >= (AW+1)'(DEPTH))
      s = s - (AW+1)'(DEPTH);
    return s[AW-1:0];
  endfunction : step

  // 8 bytes of room, and a free packet slot unless mid-packet
  assign bb.ready = (used_reg <= CW'(DEPTH - BB_MIN_FREE))
                    && (in_pkt_reg || pkt_cnt_reg < 4'(MAX_PKTS));
  assign wr_pad  = bb.eop && !wr_odd_reg;
  assign rd_word = mem[rd_ptr_reg];
  assign rd_pad  = rd_word[E_EOP] && !rd_odd_reg;
  assign rd_end  = sending_reg && rd_word[E_EOP];
  assign start   = eg_gnt && eg_req_reg;

  always_ff @(posedge ref_clk) begin
    if (bb.valid)
      mem[wr_ptr_reg] <= {bb.sop, bb.eop, bb.stomp, bb.data};
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      wr_odd_reg <= 1'b0;
      in_pkt_reg <= 1'b0;
    end else if (bb.valid) begin
      wr_ptr_reg <= step(wr_ptr_reg, wr_pad);
      wr_odd_reg <= bb.eop ? 1'b0 : ~wr_odd_reg;
      in_pkt_reg <= !bb.eop;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      used_reg <= '0;
      pkt_cnt_reg <= '0;
      done_cnt_reg <= '0;
    end else begin
      used_reg <= used_reg
                  + (bb.valid ? (wr_pad ? CW'(2) : CW'(1)) : CW'(0))
                  - (sending_reg ? (rd_pad ? CW'(2) : CW'(1)) : CW'(0));
      pkt_cnt_reg <= pkt_cnt_reg + 4'(bb.valid && bb.sop) - 4'(rd_end);
      done_cnt_reg <= done_cnt_reg + 4'(bb.valid && bb.eop) - 4'(rd_end);
    end
  end

  // request only for whole packets, oldest first
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eg_req_reg <= 1'b0;
      sending_reg <= 1'b0;
      rd_ptr_reg <= '0;
      rd_odd_reg <= 1'b0;
    end else begin
      eg_req_reg <= (done_cnt_reg != 4'h0) && !sending_reg && !start;
      if (start)
        sending_reg <= 1'b1;
      else if (rd_end)
        sending_reg <= 1'b0;
      if (sending_reg) begin
        rd_ptr_reg <= step(rd_ptr_reg, rd_pad);
        rd_odd_reg <= rd_word[E_EOP] ? 1'b0 : ~rd_odd_reg;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eg_valid_reg <= 1'b0;
      eg_sop_reg <= 1'b0;
      eg_eop_reg <= 1'b0;
      eg_stomp_reg <= 1'b0;
      eg_data_reg <= '0;
    end else begin
      eg_valid_reg <= sending_reg;
      eg_sop_reg <= sending_reg && rd_word[E_SOP];
      eg_eop_reg <= sending_reg && rd_word[E_EOP];
      eg_stomp_reg <= sending_reg && rd_word[E_STOMP];
      eg_data_reg <= rd_word[DATUM_W-1:0];
      if (rd_word[E_SOP])
        eg_data_reg[TTL_LSB +: TTL_W] <= TTL_MAX;
    end
  end

  assign eg_req   = eg_req_reg;
  assign eg_valid = eg_valid_reg;
  assign eg_sop   = eg_sop_reg;
  assign eg_eop   = eg_eop_reg;
  assign eg_stomp = eg_stomp_reg;
  assign eg_data  = eg_data_reg;

  sequence s_grant;
    eg_gnt && eg_req_reg;
  endsequence
  sequence s_burst_head;
    ##2 (eg_valid_reg && eg_sop_reg);
  endsequence

  a_grant_stream: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_grant |-> s_burst_head) else $error("grant not followed by first datum");
  a_req_whole: assert property (@(posedge ref_clk) disable iff (sys_rst)
    eg_req_reg |-> done_cnt_reg != 4'h0) else $error("request without complete packet");
  a_ttl_max: assert property (@(posedge ref_clk) disable iff (sys_rst)
    eg_valid_reg && eg_sop_reg |-> eg_data_reg[TTL_LSB +: TTL_W] == TTL_MAX)
    else $error("ttl not forced to maximum");
  a_ready_room: assert property (@(posedge ref_clk) disable iff (sys_rst)
    bb.valid |-> used_reg <= CW'(DEPTH - 1)) else $error("write into full buffer");
  a_pkt_cap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pkt_cnt_reg <= 4'(MAX_PKTS)) else $error("more than eight packets held");
  a_stomp_last: assert property (@(posedge ref_clk) disable iff (sys_rst)
    eg_valid_reg && eg_stomp_reg |-> eg_eop_reg) else $error("stomp off last datum");
endmodule : bcast_buffer

// [logic/replication_engine.sv]
// Purpose: multicast work queue with group lookup and broadcast buffers
// Assumes: fabric and group table run on ref_clk
// Notes: 4x mode, one 32-bit datum per clock in each direction
`timescale 1ns/1ps

// Function
// - work queue holds 2208 bytes
// - stop fabric once 1936 bytes held
// - pick group after first 8 bytes
// - always clear ingress port from mask
// - optionally clear latency-violating ports from mask
// - work queue always cuts through
// - stomped or errored packets replicated, last datum flagged
// - aged packets still replicated, not discarded
// - broadcast buffer: one 276-byte or eight small
// - store in 8-byte units, send unchanged
// - egress request only after whole packet
// - after grant, stream one datum per clock
// - datum is 32 bits 4x, 8 bits 1x
// - stomped copies forwarded, never discarded
// - broadcast buffer forces ttl to seven
// - source and destination identifiers untouched
// - strict fifo order in queue and buffers
// - drop packet whose group was disassociated
// - copies written concurrently on dedicated path
// - entry matches 16-bit or 8-bit destination
// - empty vector drops packet silently
// - buffer ready while 8 bytes free
module replication_engine
  import repl_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          fab_valid,
  input  wire logic                          fab_sop,
  input  wire logic                          fab_eop,
  input  wire logic                          fab_stomp,
  input  wire logic                          fab_err,
  input  wire logic [DATUM_W-1:0]            fab_data,
  output logic                               wq_stop,
  input  wire logic [GROUPS-1:0]             grp_valid,
  input  wire logic [GROUPS-1:0]             grp_large,
  input  wire logic [GROUPS-1:0][15:0]       grp_dest,
  input  wire logic [GROUPS-1:0][PORTS-1:0]  grp_mask,
  input  wire logic [PORTS-1:0]              lat_viol,
  input  wire logic                          lat_prune_en,
  input  wire logic [PORTS-1:0]              eg_gnt,
  output logic [PORTS-1:0]                   eg_req,
  output logic [PORTS-1:0]                   eg_valid,
  output logic [PORTS-1:0]                   eg_sop,
  output logic [PORTS-1:0]                   eg_eop,
  output logic [PORTS-1:0]                   eg_stomp,
  output logic [PORTS-1:0][DATUM_W-1:0]      eg_data
);
  localparam int DW = $clog2(DESC_DEPTH);
  localparam int UW = $clog2(WQ_WORDS + 1);

  // queue storage, one entry per datum slot
  logic [ENTRY_W-1:0]  wq_mem [WQ_WORDS];
  logic [WQ_PTR_W-1:0] wr_ptr_reg;
  logic [WQ_PTR_W-1:0] rd_ptr_reg;
  logic [UW-1:0]       used_reg;
  logic                wr_odd_reg;
  logic                rd_odd_reg;
  logic                wq_stop_reg;

  // header capture
  logic [1:0]          hdr_cnt_reg;
  logic [DATUM_W-1:0]  word0_reg;

  // per-packet descriptors, written once the header is in
  logic [PORTS-1:0]    desc_vec [DESC_DEPTH];
  logic [GRP_W-1:0]    desc_grp [DESC_DEPTH];
  logic [PORT_W-1:0]   desc_src [DESC_DEPTH];
  logic [DW:0]         desc_wr_reg;
  logic [DW:0]         desc_rd_reg;

  // read side
  rd_state_type        rd_state_reg;
  logic [PORTS-1:0]    cur_vec_reg;
  logic [PORT_W-1:0]   cur_src_reg;

  logic                wq_full;
  logic                wr_fire;
  logic                wr_pad;
  logic                hdr_done;
  logic                gm_hit;
  logic [GRP_W-1:0]    gm_idx;
  logic [PORTS-1:0]    gm_mask;
  logic [PORTS-1:0]    new_vec;
  logic [PORT_W-1:0]   new_src;
  logic                desc_empty;
  logic                desc_full;
  logic                pop;
  logic [PORTS-1:0]    pop_vec;
  logic [GRP_W-1:0]    pop_grp;
  logic [ENTRY_W-1:0]  rd_word;
  logic                avail;
  logic                rd_pad;
  logic [PORTS-1:0]    bb_ready;
  logic [PORTS-1:0]    bb_valid;
  logic                all_ready;
  logic                send_fire;
  logic                drop_fire;
  logic                rd_adv;

  function automatic logic [WQ_PTR_W-1:0] wq_step(input logic [WQ_PTR_W-1:0] p,
                                                  input logic two);
    logic [WQ_PTR_W:0] s;
    s = {1'b0, p} + {{(WQ_PTR_W-1){1'b0}}, two, ~two};
    if (s >= (WQ_PTR_W+1)'(WQ_WORDS))
      s = s - (WQ_PTR_W+1)'(WQ_WORDS);
    return s[WQ_PTR_W-1:0];
  endfunction : wq_step

  // ---------------- ingress side ----------------
  // keeps room for a datum and its pad; fabric is meant to stop earlier
  assign wq_full  = used_reg > UW'(WQ_WORDS - 2);
  assign desc_full = desc_wr_reg == {~desc_rd_reg[DW], desc_rd_reg[DW-1:0]};
  assign wr_fire  = fab_valid && !wq_full;
  assign wr_pad   = fab_eop && !wr_odd_reg;
  assign hdr_done = wr_fire && !fab_sop && hdr_cnt_reg == 2'(HDR_DATUMS - 1);

  // the datum completing the first 8 bytes selects the group
  group_match u_match (
    .word0     (word0_reg),
    .word1     (fab_data),
    .grp_valid (grp_valid),
    .grp_large (grp_large),
    .grp_dest  (grp_dest),
    .grp_mask  (grp_mask),
    .hit       (gm_hit),
    .grp_idx   (gm_idx),
    .mask      (gm_mask)
  );

  assign new_src = word0_reg[SRC_PORT_LSB +: PORT_W];
  always_comb begin
    new_vec = gm_hit ? gm_mask : '0;
    new_vec = new_vec & ~(PORTS'(1) << new_src);
    if (lat_prune_en)
      new_vec = new_vec & ~lat_viol;
  end

  // stomp or crc error marks only the last datum; age expiry is not looked at
  always_ff @(posedge ref_clk) begin
    if (wr_fire)
      wq_mem[wr_ptr_reg] <= {fab_sop, fab_eop, fab_eop && (fab_stomp || fab_err),
                             fab_data};
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      wr_odd_reg <= 1'b0;
    end else if (wr_fire) begin
      wr_ptr_reg <= wq_step(wr_ptr_reg, wr_pad);
      wr_odd_reg <= fab_eop ? 1'b0 : ~wr_odd_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_cnt_reg <= '0;
      word0_reg <= '0;
    end else if (wr_fire) begin
      if (fab_sop) begin
        hdr_cnt_reg <= 2'h1;
        word0_reg <= fab_data;
      end else if (hdr_cnt_reg < 2'(HDR_DATUMS)) begin
        hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
      end
    end
  end

  // descriptor fifo cannot overflow: each packet takes at least 8 bytes
  always_ff @(posedge ref_clk) begin
    if (hdr_done && !desc_full) begin
      desc_vec[desc_wr_reg[DW-1:0]] <= new_vec;
      desc_grp[desc_wr_reg[DW-1:0]] <= gm_idx;
      desc_src[desc_wr_reg[DW-1:0]] <= new_src;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      desc_wr_reg <= '0;
    else if (hdr_done && !desc_full)
      desc_wr_reg <= desc_wr_reg + 1'b1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      used_reg <= '0;
    else
      used_reg <= used_reg
                  + (wr_fire ? (wr_pad ? UW'(2) : UW'(1)) : UW'(0))
                  - (rd_adv ? (rd_pad ? UW'(2) : UW'(1)) : UW'(0));
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      wq_stop_reg <= 1'b0;
    else
      wq_stop_reg <= used_reg >= UW'(WQ_STOP_WORDS);
  end
  assign wq_stop = wq_stop_reg;

  // ---------------- replication side ----------------
  assign desc_empty = desc_wr_reg == desc_rd_reg;
  assign pop        = rd_state_reg == RD_IDLE && !desc_empty;
  assign pop_vec    = desc_vec[desc_rd_reg[DW-1:0]];
  assign pop_grp    = desc_grp[desc_rd_reg[DW-1:0]];
  // cut-through once the first 8 bytes are in; count, not pointers, so full never looks empty
  assign avail      = used_reg != '0;
  assign rd_word    = wq_mem[rd_ptr_reg];
  assign rd_pad     = rd_word[E_EOP] && !rd_odd_reg;
  assign all_ready  = &(bb_ready | ~cur_vec_reg);
  assign send_fire  = rd_state_reg == RD_SEND && avail && all_ready;
  assign drop_fire  = rd_state_reg == RD_DROP && avail;
  assign rd_adv     = send_fire || drop_fire;
  assign bb_valid   = send_fire ? cur_vec_reg : '0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state_reg <= RD_IDLE;
      cur_vec_reg <= '0;
      cur_src_reg <= '0;
      desc_rd_reg <= '0;
    end else begin
      unique case (rd_state_reg)
        RD_IDLE: begin
          if (pop) begin
            desc_rd_reg <= desc_rd_reg + 1'b1;
            cur_vec_reg <= pop_vec;
            cur_src_reg <= desc_src[desc_rd_reg[DW-1:0]];
            // no target or group gone: flush quietly
            if (pop_vec == '0 || !grp_valid[pop_grp])
              rd_state_reg <= RD_DROP;
            else
              rd_state_reg <= RD_SEND;
          end
        end
        RD_SEND: begin
          if (send_fire && rd_word[E_EOP])
            rd_state_reg <= RD_IDLE;
        end
        RD_DROP: begin
          if (drop_fire && rd_word[E_EOP])
            rd_state_reg <= RD_IDLE;
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_reg <= '0;
      rd_odd_reg <= 1'b0;
    end else if (rd_adv) begin
      rd_ptr_reg <= wq_step(rd_ptr_reg, rd_pad);
      rd_odd_reg <= rd_word[E_EOP] ? 1'b0 : ~rd_odd_reg;
    end
  end

  // one buffer per egress port, every buffer in cur_vec_reg fed in the same cycle
  for (genvar p = 0; p < PORTS; p++) begin : g_bb
    bcast_if bbi ();
    assign bbi.valid = bb_valid[p];
    assign bbi.sop   = rd_word[E_SOP];
    assign bbi.eop   = rd_word[E_EOP];
    assign bbi.stomp = rd_word[E_STOMP];
    assign bbi.data  = rd_word[DATUM_W-1:0];
    assign bb_ready[p] = bbi.ready;
    bcast_buffer u_bb (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .bb       (bbi),
      .eg_gnt   (eg_gnt[p]),
      .eg_req   (eg_req[p]),
      .eg_valid (eg_valid[p]),
      .eg_sop   (eg_sop[p]),
      .eg_eop   (eg_eop[p]),
      .eg_stomp (eg_stomp[p]),
      .eg_data  (eg_data[p])
    );
  end

  a_wq_capacity: assert property (@(posedge ref_clk) disable iff (sys_rst)
    used_reg <= UW'(WQ_WORDS)) else $error("work queue over capacity");
  a_stop_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (used_reg >= UW'(WQ_STOP_WORDS)) ##1 (used_reg >= UW'(WQ_STOP_WORDS)) |-> wq_stop_reg)
    else $error("stop not raised at threshold");
  a_no_self: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_state_reg == RD_SEND |-> !cur_vec_reg[cur_src_reg])
    else $error("copy aimed at ingress port");
  a_empty_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pop && pop_vec == '0 |=> rd_state_reg == RD_DROP) else $error("empty vector not dropped");
  a_drop_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_state_reg == RD_DROP |-> bb_valid == '0) else $error("dropped packet reached buffer");
  a_concurrent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    send_fire |-> bb_valid == cur_vec_reg && (bb_ready & cur_vec_reg) == cur_vec_reg)
    else $error("copies not written together");
endmodule : replication_engine

// [bench/egress_sink.sv]
// Purpose: egress port buffers facing the broadcast buffers
// Assumes: each grant is one registered cycle, taken with eg_req high
// Notes: slow mode grants only every eighth cycle; stall holds all grants
`timescale 1ns/1ps
module egress_sink
  import repl_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             stall,
  input  wire logic             slow,
  input  wire logic [PORTS-1:0] eg_req,
  output logic      [PORTS-1:0] eg_gnt
);
  logic [2:0] tick_reg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) tick_reg <= 3'h0;
    else tick_reg <= tick_reg + 3'h1;
  end
  // single-cycle grant so one request is never taken twice; datums are
  // accepted as they arrive, no stall path exists
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) eg_gnt <= '0;
    else eg_gnt <= eg_req & ~eg_gnt & {PORTS{!stall && (!slow || tick_reg == 3'h0)}};
  end
endmodule : egress_sink

// [bench/tb_replication_engine.sv]
// Purpose: self-checking bench of the replication engine
// Assumes: group 0 is 16-bit id 1234, group 1 is 8-bit id 44
// Notes: expected egress datums queued per port by the driver
`timescale 1ns/1ps
module tb_replication_engine;
  import repl_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, stall = 1'b0, slow = 1'b0;
  logic fab_valid = 1'b0, fab_sop = 1'b0, fab_eop = 1'b0;
  logic fab_stomp = 1'b0, fab_err = 1'b0, wq_stop, lat_prune_en = 1'b0;
  logic [DATUM_W-1:0] fab_data = '0;
  logic [PORTS-1:0] lat_viol = '0, eg_gnt, eg_req, eg_valid, eg_sop, eg_eop, eg_stomp;
  logic [GROUPS-1:0][15:0] grp_dest = {96'h0, 16'h0044, 16'h1234};
  logic [GROUPS-1:0] grp_valid = 8'h03, grp_live = 8'h03;
  logic [GROUPS-1:0][PORTS-1:0] grp_mask = {96'h0, 16'h0008, 16'h0027};
  logic [PORTS-1:0][DATUM_W-1:0] eg_data;
  logic [ENTRY_W-1:0] exp_q[PORTS][$];
  logic [ENTRY_W-1:0] e;
  logic [31:0] r;
  integer seed = 32'hd0d930b0;
  int miscompares = 0, checks_done = 0, n;
  initial forever #10 ref_clk = ~ref_clk;
  replication_engine replication_engine_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .fab_valid(fab_valid), .fab_sop(fab_sop), .fab_eop(fab_eop), .fab_stomp(fab_stomp),
    .fab_err(fab_err), .fab_data(fab_data), .wq_stop(wq_stop), .grp_valid(grp_valid),
    .grp_large(8'h01), .grp_dest(grp_dest), .grp_mask(grp_mask), .lat_viol(lat_viol),
    .lat_prune_en(lat_prune_en), .eg_gnt(eg_gnt), .eg_req(eg_req), .eg_valid(eg_valid),
    .eg_sop(eg_sop), .eg_eop(eg_eop), .eg_stomp(eg_stomp), .eg_data(eg_data));
  egress_sink egress_sink_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall),
    .slow(slow), .eg_req(eg_req), .eg_gnt(eg_gnt));
  task automatic check(input string what, input logic [ENTRY_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task automatic send_pkt(input logic [3:0] src, input logic tt, input int len,
                          input logic bad, input logic use_err);
    logic [DATUM_W-1:0] d;
    logic [PORTS-1:0] vec;
    int k;
    k = 0;
    if (wq_stop === 1'b1) fab_valid = 1'b0;
    while (wq_stop === 1'b1 && k < 5000) begin @(posedge ref_clk); #1; k++; end
    if (k == 5000) begin miscompares++; tally_and_finish(); end
    vec = grp_mask[tt] & ~(16'h1 << src) & ~(lat_prune_en ? lat_viol : 16'h0);
    if (!grp_live[tt]) vec = '0;
    for (int i = 0; i < len; i++) begin
      d = $random(seed);
      if (i == 0) begin d[30:27] = src; d[26:24] = 3'h0; d[20] = tt; end
      if (i == 1 && tt) d[31:24] = 8'h44;
      if (i == 1 && !tt) d[31:16] = 16'h1234;
      fab_valid = 1'b1; fab_sop = (i == 0); fab_eop = (i == len - 1); fab_data = d;
      fab_stomp = bad && !use_err && i == len - 1; fab_err = bad && use_err && i == len - 1;
      if (i == 0) d[26:24] = TTL_MAX;
      for (int p = 0; p < PORTS; p++) if (vec[p]) exp_q[p].push_back({i == 0, i == len - 1,
        bad && i == len - 1, d});
      @(posedge ref_clk); #1;
    end
  endtask : send_pkt
  task automatic drain(input string name);
    int k, m;
    fab_valid = 1'b0;
    for (k = 0; k < 20000; k++) begin
      m = 0;
      for (int p = 0; p < PORTS; p++) m += exp_q[p].size();
      if (m == 0) break;
      @(posedge ref_clk); #1;
    end
    if (k == 20000) begin miscompares++; tally_and_finish(); end
    repeat (8) @(posedge ref_clk); #1;
    $display("test %s done", name);
  endtask : drain
  // sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge ref_clk) if (!sys_rst) for (int p = 0; p < PORTS; p++)
    if (eg_valid[p] === 1'b1) begin
      if (exp_q[p].size() == 0) check("unexpected datum", 1'b1, 1'b0);
      else begin
        e = exp_q[p].pop_front();
        check("egress datum", {eg_sop[p], eg_eop[p], eg_stomp[p], eg_data[p]}, e);
      end
    end
  initial begin
    repeat (20) @(posedge ref_clk); #1;
    sys_rst = 1'b0;
    send_pkt(4'h1, 1'b0, 5, 1'b0, 1'b0);
    send_pkt(4'h4, 1'b1, 2, 1'b0, 1'b0);
    send_pkt(4'h3, 1'b1, 3, 1'b0, 1'b0);
    send_pkt(4'h0, 1'b0, 9, 1'b1, 1'b0);
    send_pkt(4'h2, 1'b0, 3, 1'b1, 1'b1);
    drain("basic");
    lat_viol = 16'h0004; lat_prune_en = 1'b1;
    send_pkt(4'h1, 1'b0, 4, 1'b0, 1'b0);
    drain("prune");
    lat_viol = '0; lat_prune_en = 1'b0; stall = 1'b1; grp_live = 8'h01;
    // group 1 packet waits behind a blocked one, then loses its association
    repeat (9) send_pkt(4'h1, 1'b0, 2, 1'b0, 1'b0);
    send_pkt(4'h0, 1'b1, 2, 1'b0, 1'b0);
    grp_valid = 8'h01; stall = 1'b0;
    drain("unbind");
    grp_valid = 8'h03; grp_live = 8'h03; slow = 1'b1;
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      send_pkt(r[7:4], r[0], 2 + int'(r[15:8]) % 68, r[1] & r[2], r[3]);
    end
    drain("random");
    slow = 1'b0; stall = 1'b1;
    for (n = 0; n < 600 && wq_stop !== 1'b1; n++) send_pkt(4'h1, 1'b0, 2, 1'b0, 1'b0);
    check("stop point", n >= WQ_STOP_BYTES / 8 && n < WQ_BYTES / 8, 1'b1);
    stall = 1'b0;
    drain("fill");
    tally_and_finish();
  end
endmodule : tb_replication_engine
